// ---- core/ssf_pkg.sv ----
package ssf_pkg;
  localparam int        SSF_AW          = 4;
  localparam int        SSF_DW          = 16;
  // word registers, byte addresses
  localparam bit [3:0]  SSF_ADDR_DATA   = 4'h0;
  localparam bit [3:0]  SSF_ADDR_CTRL   = 4'h4;
  localparam bit [3:0]  SSF_ADDR_STAT   = 4'h8;
  localparam bit [3:0]  SSF_ADDR_IRQ    = 4'hc;
  // status bit positions
  localparam int        SSF_BSY_BIT     = 0;
  localparam int        SSF_RBF_BIT     = 1;
  localparam int        SSF_OVR_BIT     = 2;
  // control bit positions
  localparam int        SSF_EN_BIT      = 0;
  localparam int        SSF_MST_BIT     = 1;
  localparam int        SSF_W16_BIT     = 2;
  localparam int        SSF_EIO_BIT     = 4;
  localparam int        SSF_EIR_BIT     = 5;
  localparam int        SSF_EIW_BIT     = 6;
  localparam bit [15:0] SSF_CTRL_RST    = 16'h0000;
  localparam bit [15:0] SSF_CTRL_MASK   = 16'h0077;
  localparam bit [15:0] SSF_STAT_RST    = 16'h0000;
  localparam bit [2:0]  SSF_IRQ_RST     = 3'h0;
  localparam bit [4:0]  SSF_BITS8       = 5'h08;
  localparam bit [4:0]  SSF_BITS16      = 5'h10;
  localparam bit [7:0]  SSF_DIV_DEFAULT = 8'h04;

  typedef struct packed {
    logic            wr;
    logic            rd;
    logic [3:0]      addr;
    logic [15:0]     wdata;
  } ssf_bus_s;

  typedef struct packed {
    logic receive_overrun_flag;
    logic read_buffer_full_flag;
    logic shifter_busy_flag;
  } ssf_flags_s;
endpackage : ssf_pkg

// ---- core/ssf_shifter.sv ----
`timescale 1ns/1ns
module ssf_shifter
  import ssf_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic          clr_i,
  input  wire logic          start_i,
  input  wire logic          sample_i,
  input  wire logic          shift_i,
  input  wire logic          sdi_i,
  input  wire logic [DW-1:0] tx_i,
  input  wire logic [4:0]    nbits_i,
  output logic      [DW-1:0] rx_o,
  output logic               sdo_o,
  output logic               active_o,
  output logic               done_o
);
  logic [DW-1:0] sh_q;
  logic [4:0]    cnt_q;
  logic          out_q;

  function automatic logic top_bit(input logic [DW-1:0] v, input logic [4:0] n);
    return (n == SSF_BITS8) ? v[7] : v[DW-1];
  endfunction : top_bit

  assign rx_o  = sh_q;
  // the output bit has its own flop and moves on the trailing edge,
  // so the far side never samples it in the instant that it changes
  assign sdo_o = out_q;

  // done_o pulses one cycle after the last sampling edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_q     <= '0;
      cnt_q    <= '0;
      out_q    <= 1'b0;
      active_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clr_i) begin
        cnt_q    <= '0;
        active_o <= 1'b0;
      end else if (start_i && !active_o) begin
        sh_q     <= tx_i;
        cnt_q    <= '0;
        out_q    <= top_bit(tx_i, nbits_i);
        active_o <= 1'b1;
      end else if (active_o && sample_i) begin
        sh_q <= {sh_q[DW-2:0], sdi_i};
        if (cnt_q + 5'h01 == nbits_i) begin
          active_o <= 1'b0;
          done_o   <= 1'b1;
        end
        cnt_q <= cnt_q + 5'h01;
      end else if (active_o && shift_i) begin
        out_q <= top_bit(sh_q, nbits_i);
      end
    end
  end
endmodule : ssf_shifter

// ---- core/ssf_sync.sv ----
`timescale 1ns/1ns
module ssf_sync
  import ssf_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // meta_q feeds nothing but q_o
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : ssf_sync

// ---- core/ssf_top.sv ----
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module ssf_top
  import ssf_pkg::*;
#(
  parameter int DW = SSF_DW
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [SSF_AW-1:0] addr_i,
  input  wire logic [DW-1:0]     wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DW-1:0]     rdata_o,
  input  wire logic              shift_clock_pin_i,
  output logic                   shift_clock_pin_o,
  output logic                   shift_clock_pin_oe_o,
  input  wire logic              port_select_n_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  output logic                   irq_o
);
  ssf_bus_s   bus;
  ssf_flags_s flg_q;
  logic [15:0]   ctrl_q;
  logic [2:0]    ien_q;
  logic [2:0]    irq_st_q;
  logic [DW-1:0] txd_q;
  logic [DW-1:0] rbuf_q;
  logic          pend_q;
  logic [DW-1:0] pend_data_q;
  logic          sel_prev_q;
  logic [7:0]    div_q;
  logic          sck_q;
  logic          sck_prev_q;
  logic [2:0]    pins_s;
  logic          sck_s;
  logic          sel_s;
  logic          sdi_s;
  logic          en;
  logic          mst;
  logic          slv_lead;
  logic          slv_trail;
  logic          m_lead;
  logic          m_trail;
  logic          sh_active;
  logic          sh_done;
  logic [DW-1:0] sh_rx;
  logic          sh_sdo;
  logic          wr_data;
  logic          rd_data;
  logic          wr_stat;
  logic          start_xfer;
  logic [4:0]    nbits;
  logic [DW-1:0] rx_word;
  logic          bsy_fall;
  logic          rbf_rise;
  logic          ovr_rise;
  logic          slv_sel_rise;
  logic          slv_cut;
  logic          word_direct;
  logic          word_park;
  logic          pend_pop;
  logic          bsy_set;
  logic          bsy_clr;
  logic          rbf_set;
  logic          rbf_clr;
  logic          ovr_set;
  logic          ovr_clr;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : hit

  assign bus     = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
  assign en      = ctrl_q[SSF_EN_BIT];
  assign mst     = ctrl_q[SSF_MST_BIT];
  assign nbits   = ctrl_q[SSF_W16_BIT] ? SSF_BITS16 : SSF_BITS8;
  assign wr_data = bus.wr && hit(bus.addr, SSF_ADDR_DATA);
  assign rd_data = bus.rd && hit(bus.addr, SSF_ADDR_DATA);
  assign wr_stat = bus.wr && hit(bus.addr, SSF_ADDR_STAT);
  assign rx_word = ctrl_q[SSF_W16_BIT] ? sh_rx : {{(DW-8){1'b0}}, sh_rx[7:0]};

  // pins come from another domain: two flops before any use
  // select is inverted ahead of the flops so that their reset value reads as not selected
  ssf_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    ({shift_clock_pin_i, ~port_select_n_i, sdi_i}),
    .q_o    (pins_s)
  );
  assign sck_s = pins_s[2];
  assign sel_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // slave samples on the rising edge, shifts out on the falling edge
  assign slv_lead  = en && !mst && sel_s && sck_s && !sck_prev_q;
  assign slv_trail = en && !mst && sel_s && !sck_s && sck_prev_q;
  // the slave loads its word as select goes active, so its first bit is out before the first clock
  assign slv_sel_rise = en && !mst && sel_s && !sel_prev_q;
  assign slv_cut      = !mst && !sel_s;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // master clock divider; a fixed ratio keeps the demo small
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
      sck_q <= 1'b0;
    end else if (!en || !mst || !sh_active) begin
      div_q <= '0;
      sck_q <= 1'b0;
    end else if (div_q == SSF_DIV_DEFAULT) begin
      div_q <= '0;
      sck_q <= ~sck_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign m_lead  = en && mst && sh_active && (div_q == SSF_DIV_DEFAULT) && !sck_q;
  assign m_trail = en && mst && sh_active && (div_q == SSF_DIV_DEFAULT) && sck_q;

  // a transfer starts on a data write (master) or on select going active (slave)
  assign start_xfer = en && !sh_active &&
                      ((mst && wr_data) || slv_sel_rise);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_s;
    end
  end

  ssf_shifter #(.DW(DW)) u_shift (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .clr_i    (!en || slv_cut),
    .start_i  (start_xfer),
    .sample_i (mst ? m_lead : slv_lead),
    .shift_i  (mst ? m_trail : slv_trail),
    .sdi_i    (sdi_s),
    .tx_i     (wr_data ? bus.wdata : txd_q),
    .nbits_i  (nbits),
    .rx_o     (sh_rx),
    .sdo_o    (sh_sdo),
    .active_o (sh_active),
    .done_o   (sh_done)
  );

  // a deselect ends a cut slave frame; the serial output is the shifter's own flop
  assign sdo_o = sh_sdo;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_clock_pin_o    <= 1'b0;
      shift_clock_pin_oe_o <= 1'b0;
      sdo_oe_o             <= 1'b0;
    end else begin
      shift_clock_pin_o    <= sck_q;
      shift_clock_pin_oe_o <= en && mst;
      sdo_oe_o             <= en && (mst || sel_s);
    end
  end

  // control and transmit data registers; the interrupt enables are control bits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q <= SSF_CTRL_RST;
      txd_q  <= '0;
    end else begin
      if (bus.wr && hit(bus.addr, SSF_ADDR_CTRL)) begin
        ctrl_q <= bus.wdata & SSF_CTRL_MASK;
      end
      if (wr_data) begin
        txd_q <= bus.wdata;
      end
    end
  end

  // a finished word goes straight to the buffer when it is empty or being read out now with no word waiting
  assign word_direct = sh_done && (!flg_q.read_buffer_full_flag || (rd_data && !pend_q));
  // otherwise it waits behind the unread buffer; a pop and a new word in one cycle keep both
  assign word_park   = sh_done && !word_direct;
  assign pend_pop    = rd_data && pend_q;
  assign bsy_set     = wr_data || slv_lead;
  // a waiting word keeps busy up until software pops it, unless it parks in the same cycle as a pop
  assign bsy_clr     = word_direct || (pend_pop && !sh_active);
  assign rbf_set     = word_direct;
  assign rbf_clr     = rd_data && !pend_q;
  assign ovr_set     = mst && start_xfer && flg_q.read_buffer_full_flag && pend_q;
  assign ovr_clr     = wr_stat && bus.wdata[SSF_OVR_BIT];

  // read buffer and waiting word
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rbuf_q      <= '0;
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else if (!en) begin
      pend_q <= 1'b0;
    end else begin
      if (word_direct) begin
        rbuf_q <= rx_word;
      end else if (pend_pop) begin
        rbuf_q <= pend_data_q;
      end
      if (word_park) begin
        pend_q      <= 1'b1;
        pend_data_q <= rx_word;
      end else if (pend_pop) begin
        pend_q <= 1'b0;
      end
    end
  end

  // status flags; sets win over clears, a disable clears all three, all clocked
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flg_q <= '0;
    end else if (!en) begin
      flg_q <= '0;
    end else begin
      if (bsy_set) begin
        flg_q.shifter_busy_flag <= 1'b1;
      end else if (bsy_clr) begin
        flg_q.shifter_busy_flag <= 1'b0;
      end
      if (rbf_set) begin
        flg_q.read_buffer_full_flag <= 1'b1;
      end else if (rbf_clr) begin
        flg_q.read_buffer_full_flag <= 1'b0;
      end
      if (ovr_set) begin
        flg_q.receive_overrun_flag <= 1'b1;
      end else if (ovr_clr) begin
        flg_q.receive_overrun_flag <= 1'b0;
      end
    end
  end

  // interrupt: sticky events, write one to clear, gated by enables
  logic [2:0] flg_prev_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flg_prev_q <= '0;
    end else begin
      flg_prev_q <= flg_q;
    end
  end
  assign bsy_fall = flg_prev_q[SSF_BSY_BIT] && !flg_q.shifter_busy_flag;
  assign rbf_rise = !flg_prev_q[SSF_RBF_BIT] && flg_q.read_buffer_full_flag;
  assign ovr_rise = !flg_prev_q[SSF_OVR_BIT] && flg_q.receive_overrun_flag;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st_q <= SSF_IRQ_RST;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == SSF_BSY_BIT && bsy_fall) || (i == SSF_RBF_BIT && rbf_rise) ||
            (i == SSF_OVR_BIT && ovr_rise)) begin
          irq_st_q[i] <= 1'b1;
        end else if (bus.wr && hit(bus.addr, SSF_ADDR_IRQ) && bus.wdata[i]) begin
          irq_st_q[i] <= 1'b0;
        end
      end
    end
  end
  assign ien_q = {ctrl_q[SSF_EIO_BIT], ctrl_q[SSF_EIR_BIT], ctrl_q[SSF_EIW_BIT]};
  assign irq_o = |(irq_st_q & ien_q);

  // read data one cycle after the strobe; overrun never sets in slave mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        SSF_ADDR_DATA: rdata_o <= rbuf_q;
        SSF_ADDR_CTRL: rdata_o <= ctrl_q;
        SSF_ADDR_STAT: rdata_o <= {{(DW-3){1'b0}}, flg_q};
        SSF_ADDR_IRQ:  rdata_o <= {{(DW-3){1'b0}}, irq_st_q};
        default:       rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : ssf_top

// ---- testbench/ssf_chk.sv ----
`timescale 1ns/1ns
module ssf_chk
  import ssf_pkg::*;
#(
  parameter int DW = SSF_DW
) (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic [SSF_AW-1:0] addr_i,
  input wire logic [DW-1:0]     wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DW-1:0]     rdata_o,
  input wire logic              irq_o
);
  logic [6:0] ctrl_q;
  logic       mst_en;
  // shadow of the control register, the checker sees only the bus and irq_o
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) ctrl_q <= '0;
    else if (wr_i && addr_i == SSF_ADDR_CTRL) ctrl_q <= wdata_i[6:0];
  end
  assign mst_en = ctrl_q[SSF_EN_BIT] && ctrl_q[SSF_MST_BIT];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_stat; rd_i && addr_i == SSF_ADDR_STAT; endsequence
  sequence s_then_stat; !wr_i ##1 s_stat; endsequence
  sequence s_ovr_seen; s_stat ##1 rdata_o[SSF_OVR_BIT]; endsequence
  AST_RSVD: assert property (s_stat |=> rdata_o[DW-1:3] == '0)
    else $error("reserved status bits set");
  AST_IDLE: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data outside read slot");
  AST_BSY_MST: assert property (wr_i && addr_i == SSF_ADDR_DATA && mst_en ##1 s_then_stat |=> rdata_o[0])
    else $error("busy not set by master write");
  AST_OVR_HOLD: assert property (s_ovr_seen ##0 !wr_i ##1 s_stat |=> rdata_o[SSF_OVR_BIT])
    else $error("overrun dropped");
  AST_OVR_W0: assert property (s_ovr_seen ##1 (wr_i && addr_i == SSF_ADDR_STAT && !wdata_i[2]) ##1 s_then_stat
    |=> rdata_o[SSF_OVR_BIT])
    else $error("overrun cleared by zero");
  AST_OVR_W1: assert property (wr_i && addr_i == SSF_ADDR_STAT && wdata_i[2] && mst_en ##1 s_then_stat
    |=> !rdata_o[SSF_OVR_BIT])
    else $error("overrun not cleared by one");
  AST_EN_CLR: assert property (wr_i && addr_i == SSF_ADDR_CTRL && !wdata_i[0] ##1 s_then_stat
    |=> rdata_o[2:0] == 3'h0)
    else $error("flags kept after disable");
  AST_IRQ_OFF: assert property (ctrl_q[6:4] == 3'h0 |-> !irq_o)
    else $error("irq with all enables clear");
endmodule : ssf_chk
bind ssf_top ssf_chk #(.DW(DW)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ---- testbench/ssf_peer.sv ----
`timescale 1ns/1ns
module ssf_peer (
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  output logic            sck_o,
  output logic            sel_n_o,
  output logic            sdi_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh_q;
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    sh_q = 8'h00;
    rx_o = 8'h00;
  end
  assign sdi_o = sh_q[7];
  // inverted fill so a stale line never repeats the last bit
  always @(negedge sck_i) sh_q <= {sh_q[6:0], ~sh_q[7]};
  always @(posedge sck_i) rx_o <= {rx_o[6:0], sdo_i};
  task automatic load(input logic [7:0] d);
    sh_q = d;
  endtask : load
  // clock stands low outside frames
  task automatic frame(input logic [7:0] d);
    sh_q = d;
    sel_n_o = 1'b0;
    #32;
    repeat (8) begin
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #32 sel_n_o = 1'b1;
  endtask : frame
endmodule : ssf_peer

// ---- testbench/ssf_top_tb.sv ----
`timescale 1ns/1ns
module ssf_top_tb import ssf_pkg::*;;
  logic        clk, rstn, wr, rd, irq, sck_out, sck_oe, sck_pin, sck_peer, sel_n, sdi, sdo, sdo_oe, sdo_pin;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic [7:0]  prx;
  int          miscompares, checks_done, cycles;
  assign sck_pin = sck_oe ? sck_out : sck_peer;
  assign sdo_pin = sdo_oe ? sdo : 1'bz;
  ssf_top #(.DW(SSF_DW)) dut (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .shift_clock_pin_i(sck_pin), .shift_clock_pin_o(sck_out), .shift_clock_pin_oe_o(sck_oe),
    .port_select_n_i(sel_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .irq_o(irq));
  ssf_peer peer (.sck_i(sck_pin), .sdo_i(sdo_pin), .sck_o(sck_peer), .sel_n_o(sel_n), .sdi_o(sdi), .rx_o(prx));
  always #4 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string w, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", w, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic stat(input string w, input logic [15:0] m, e);
    logic [15:0] s;
    rd_reg(SSF_ADDR_STAT, s);
    chk(w, s & m, e);
  endtask : stat
  task automatic wait_stat(input logic [15:0] m, e);
    logic [15:0] s;
    int          n;
    n = 0;
    s = '0;
    while (n < 100 && (s & m) !== e) begin
      rd_reg(SSF_ADDR_STAT, s);
      n++;
    end
    chk("status wait", s & m, e);
  endtask : wait_stat
  task automatic t_reset();
    logic [15:0] d;
    stat("reset status", 16'hffff, SSF_STAT_RST);
    wr_reg(4'h2, 16'hffff);
    rd_reg(4'h2, d);
    chk("unmapped", d, 16'h0000);
    wr_reg(SSF_ADDR_STAT, 16'hffff);
    stat("status write", 16'hffff, 16'h0000);
  endtask : t_reset
  task automatic t_master();
    logic [15:0] d;
    wr_reg(SSF_ADDR_CTRL, 16'h0023);
    peer.load(8'h3c);
    wr_reg(SSF_ADDR_DATA, 16'h00a5);
    stat("busy", 16'h0001, 16'h0001);
    wait_stat(16'h0003, 16'h0002);
    chk("irq", {15'h0000, irq}, 16'h0001);
    chk("peer rx", {8'h00, prx}, 16'h00a5);
    wr_reg(SSF_ADDR_CTRL, 16'h0003);
    rd_reg(SSF_ADDR_IRQ, d);
    chk("irq status", d & 16'h0002, 16'h0002);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    wr_reg(SSF_ADDR_IRQ, 16'h0007);
    rd_reg(SSF_ADDR_IRQ, d);
    chk("irq cleared", d, 16'h0000);
    rd_reg(SSF_ADDR_DATA, d);
    chk("rx word", d, 16'h003c);
    stat("popped", 16'h0003, 16'h0000);
  endtask : t_master
  task automatic t_overrun();
    logic [15:0] d;
    wr_reg(SSF_ADDR_DATA, 16'h0011);
    wait_stat(16'h0003, 16'h0002);
    wr_reg(SSF_ADDR_DATA, 16'h0022);
    // no completion flag exists here: wait out one 8-bit frame of 80 cycles
    repeat (150) @(posedge clk);
    stat("word waits", 16'h0003, 16'h0003);
    wr_reg(SSF_ADDR_DATA, 16'h0033);
    stat("overrun", 16'h0004, 16'h0004);
    stat("overrun held", 16'h0004, 16'h0004);
    wr_reg(SSF_ADDR_STAT, 16'h0003);
    stat("write zero", 16'h0007, 16'h0007);
    wr_reg(SSF_ADDR_STAT, 16'h0004);
    stat("write one", 16'h0004, 16'h0000);
    rd_reg(SSF_ADDR_DATA, d);
    stat("reload", 16'h0002, 16'h0002);
    wr_reg(SSF_ADDR_CTRL, 16'h0000);
    stat("disable", 16'h0007, 16'h0000);
  endtask : t_overrun
  task automatic t_slave();
    logic [15:0] d;
    wr_reg(SSF_ADDR_CTRL, 16'h0001);
    wr_reg(SSF_ADDR_DATA, 16'h005a);
    stat("busy by write", 16'h0001, 16'h0001);
    peer.frame(8'h96);
    wait_stat(16'h0003, 16'h0002);
    rd_reg(SSF_ADDR_DATA, d);
    chk("slave rx", d, 16'h0096);
    chk("slave tx", {8'h00, prx}, 16'h005a);
    fork
      peer.frame(8'h69);
      begin
        repeat (12) @(posedge clk);
        stat("busy by clock", 16'h0001, 16'h0001);
      end
    join
    wait_stat(16'h0003, 16'h0002);
    rd_reg(SSF_ADDR_DATA, d);
    chk("slave rx 2", d, 16'h0069);
  endtask : t_slave
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_master();
    t_overrun();
    t_slave();
    finish_test();
  end
endmodule : ssf_top_tb
